// file: crl_pkg.sv
package crl_pkg;

  // ****************************************************************
  // Line states and read kinds
  // ****************************************************************
  typedef enum logic [2:0] {
    invalid,
    unique_clean,
    unique_dirty,
    shared_clean,
    shared_dirty
  } crl_state_type;

  typedef enum logic [1:0] {
    rd_no_snoop,
    rd_snapshot,
    rd_clean
  } crl_read_type;

  // ****************************************************************
  // Response field layout and table size
  // ****************************************************************
  localparam int RESP_W         = 2;
  localparam int RESP_SHARED    = 1;
  localparam int RESP_PASSDIRTY = 0;
  localparam int LINES          = 4;
  localparam int IDX_W          = 2;

endpackage

// file: crl_end_state.sv
`timescale 1ns/1ps
module crl_end_state (
  input  wire crl_pkg::crl_read_type  read_kind,
  input  wire crl_pkg::crl_state_type start_state,
  input  wire logic [crl_pkg::RESP_W-1:0] resp,
  input  wire logic             sf_support,
  input  wire logic             opt_no_alloc,
  input  wire logic             opt_share,
  input  wire logic             opt_drop,
  output crl_pkg::crl_state_type end_state,
  output logic                  illegal
);

  // ****************************************************************
  // Expected end state and start-state and response legality
  // ****************************************************************
  wire logic is_shared = resp[crl_pkg::RESP_SHARED];
  wire logic pass_dirty = resp[crl_pkg::RESP_PASSDIRTY];
  crl_pkg::crl_state_type expected;
  crl_pkg::crl_state_type shared_form;
  logic                   exp_bad;

  always_comb begin
    expected = crl_pkg::invalid;
    exp_bad  = 1'b0;
    // Dirty-pass never legal for these read kinds; an offending response is flagged.
    if (pass_dirty) begin
      exp_bad = 1'b1;
    end
    case (read_kind)
      crl_pkg::rd_no_snoop: begin
        if (is_shared) begin
          exp_bad = 1'b1;
        end
        case (start_state)
          crl_pkg::invalid:      expected = opt_no_alloc ? crl_pkg::invalid : crl_pkg::unique_clean;
          crl_pkg::unique_clean,
          crl_pkg::shared_clean: expected = opt_no_alloc ? crl_pkg::invalid : crl_pkg::unique_clean;
          default:               expected = crl_pkg::unique_dirty;
        endcase
      end
      crl_pkg::rd_snapshot, crl_pkg::rd_clean: begin
        case (start_state)
          crl_pkg::invalid: begin
            if (read_kind == crl_pkg::rd_snapshot) begin
              expected = crl_pkg::invalid;
            end else begin
              expected = is_shared ? crl_pkg::shared_clean : crl_pkg::unique_clean;
            end
          end
          crl_pkg::unique_clean: begin
            expected = crl_pkg::unique_clean;
            exp_bad  = exp_bad | is_shared;
          end
          crl_pkg::unique_dirty: begin
            expected = crl_pkg::unique_dirty;
            exp_bad  = exp_bad | is_shared;
          end
          crl_pkg::shared_clean: expected = is_shared ? crl_pkg::shared_clean : crl_pkg::unique_clean;
          crl_pkg::shared_dirty: expected = is_shared ? crl_pkg::shared_dirty : crl_pkg::unique_dirty;
          default:               exp_bad = 1'b1;
        endcase
      end
      default: exp_bad = 1'b1;
    endcase
  end

  // ****************************************************************
  // Permitted deviations from the expected state
  // ****************************************************************
  // A non-snooping read with a filter may not record a clean line as shared.
  wire logic share_ok = !(read_kind == crl_pkg::rd_no_snoop && sf_support);
  // A clean read answered shared may be dropped even when a filter is present.
  wire logic drop_ok = !sf_support || (read_kind == crl_pkg::rd_clean && is_shared);

  always_comb begin
    shared_form = expected;
    if (opt_share) begin
      if (expected == crl_pkg::unique_dirty) begin
        shared_form = crl_pkg::shared_dirty;
      end else if (expected == crl_pkg::unique_clean && share_ok) begin
        shared_form = crl_pkg::shared_clean;
      end
    end
  end

  wire logic clean_result = (shared_form == crl_pkg::unique_clean) || (shared_form == crl_pkg::shared_clean);
  wire logic sd_drop = read_kind == crl_pkg::rd_clean && is_shared && shared_form == crl_pkg::shared_dirty;
  wire logic do_drop = opt_drop && ((clean_result && drop_ok) || sd_drop);

  // Without an option selected the expected state is taken.
  assign end_state = do_drop ? crl_pkg::invalid : shared_form;
  assign illegal   = exp_bad;

endmodule

// file: crl_line_state.sv
`timescale 1ns/1ps
module crl_line_state (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          sf_support,
  input  wire logic                          opt_no_alloc,
  input  wire logic                          opt_share,
  input  wire logic                          opt_drop,
  input  wire logic                          req_valid,
  input  wire logic [crl_pkg::IDX_W-1:0]     req_idx,
  input  wire logic                          resp_valid,
  input  wire logic [crl_pkg::IDX_W-1:0]     resp_idx,
  input  wire crl_pkg::crl_read_type         resp_kind,
  input  wire logic [crl_pkg::RESP_W-1:0]    resp_bits,
  input  wire logic                          snoop_valid,
  input  wire logic [crl_pkg::IDX_W-1:0]     snoop_idx,
  input  wire crl_pkg::crl_state_type        snoop_state,
  input  wire logic                          cmo_valid,
  input  wire logic [crl_pkg::IDX_W-1:0]     cmo_idx,
  input  wire logic                          load_valid,
  input  wire logic [crl_pkg::IDX_W-1:0]     load_idx,
  input  wire crl_pkg::crl_state_type        load_state,
  input  wire logic [crl_pkg::IDX_W-1:0]     look_idx,
  output crl_pkg::crl_state_type             look_state,
  output logic                               done,
  output crl_pkg::crl_state_type             done_state,
  output logic                               done_illegal,
  output logic                               done_snooped,
  output logic                               cmo_done
);

  // ****************************************************************
  // Line table
  // ****************************************************************
  crl_pkg::crl_state_type line_reg [crl_pkg::LINES];
  logic [crl_pkg::LINES-1:0] pend_reg;
  logic [crl_pkg::LINES-1:0] snooped_reg;
  logic [crl_pkg::LINES-1:0] pend_next;
  logic [crl_pkg::LINES-1:0] snooped_next;

  // ****************************************************************
  // Response resolution
  // ****************************************************************
  // The start state is read at response time, with a same-cycle snoop
  // forwarded, so changes made while the read was in flight are honoured.
  wire logic snoop_hit = snoop_valid && snoop_idx == resp_idx;
  wire crl_pkg::crl_state_type start_state = snoop_hit ? snoop_state : line_reg[resp_idx];
  crl_pkg::crl_state_type resolved;
  logic                   bad;

  crl_end_state u_end (
    .read_kind    (resp_kind),
    .start_state  (start_state),
    .resp         (resp_bits),
    .sf_support   (sf_support),
    .opt_no_alloc (opt_no_alloc),
    .opt_share    (opt_share),
    .opt_drop     (opt_drop),
    .end_state    (resolved),
    .illegal      (bad)
  );

  // An illegal start or response leaves the line untouched rather than guessing.
  wire logic apply_resp = resp_valid && !bad;
  wire logic snooped_now = snooped_reg[resp_idx] || snoop_hit;

  always_comb begin
    pend_next    = pend_reg;
    snooped_next = snooped_reg;
    if (snoop_valid && pend_reg[snoop_idx]) begin
      snooped_next[snoop_idx] = 1'b1;
    end
    if (resp_valid) begin
      pend_next[resp_idx]    = 1'b0;
      snooped_next[resp_idx] = 1'b0;
    end
    // A new issue in the response cycle opens a fresh window.
    if (req_valid) begin
      pend_next[req_idx]    = 1'b1;
      snooped_next[req_idx] = 1'b0;
    end
  end

  // ****************************************************************
  // State update
  // ****************************************************************
  // Priority per line: response, then snoop, then local fill. Maintenance
  // operations write nothing.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < crl_pkg::LINES; i++) begin
        line_reg[i] <= crl_pkg::invalid;
      end
    end else begin
      for (int i = 0; i < crl_pkg::LINES; i++) begin
        if (apply_resp && resp_idx == i[crl_pkg::IDX_W-1:0]) begin
          line_reg[i] <= resolved;
        end else if (snoop_valid && snoop_idx == i[crl_pkg::IDX_W-1:0]) begin
          line_reg[i] <= snoop_state;
        end else if (load_valid && load_idx == i[crl_pkg::IDX_W-1:0]) begin
          line_reg[i] <= load_state;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_reg    <= '0;
      snooped_reg <= '0;
    end else begin
      pend_reg    <= pend_next;
      snooped_reg <= snooped_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done         <= 1'b0;
      done_state   <= crl_pkg::invalid;
      done_illegal <= 1'b0;
      done_snooped <= 1'b0;
      cmo_done     <= 1'b0;
    end else begin
      done         <= resp_valid;
      done_state   <= bad ? start_state : resolved;
      done_illegal <= resp_valid && bad;
      done_snooped <= resp_valid && snooped_now;
      cmo_done     <= cmo_valid;
    end
  end

  // cmo_idx is accepted only so the port shape matches the issue path.
  wire logic unused_cmo = |cmo_idx;

  assign look_state = line_reg[look_idx];

endmodule

// file: crl_end_state_note_unused.sv
`timescale 1ns/1ps

// file: crl_line_state_asserts.sv
`timescale 1ns/1ps
module crl_line_state_asserts (
  input wire logic                       sys_clk,
  input wire logic                       rst,
  input wire logic                       sf_support,
  input wire logic                       resp_valid,
  input wire crl_pkg::crl_read_type      resp_kind,
  input wire logic [crl_pkg::RESP_W-1:0] resp_bits,
  input wire logic                       cmo_valid,
  input wire logic                       done,
  input wire crl_pkg::crl_state_type     done_state,
  input wire logic                       done_illegal,
  input wire logic                       cmo_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  done_next_a: assert property (resp_valid |=> done) else $error("done missing after response");
  done_quiet_a: assert property (!resp_valid |=> !done && !done_illegal) else $error("done without response");
  illegal_pulse_a: assert property (done_illegal |-> done) else $error("illegal flag without done");
  pass_dirty_a: assert property (resp_valid && resp_bits[crl_pkg::RESP_PASSDIRTY] |=> done_illegal)
    else $error("dirty pass on these reads not refused");
  shared_end_a: assert property (resp_valid && resp_bits == 2'h2 |=> done_illegal ||
    done_state inside {crl_pkg::invalid, crl_pkg::shared_clean, crl_pkg::shared_dirty})
    else $error("shared answer left a unique line");
  nosnoop_shared_a: assert property (resp_valid && resp_kind == crl_pkg::rd_no_snoop &&
    resp_bits[crl_pkg::RESP_SHARED] |=> done_illegal) else $error("shared answer to non-snooping read taken");
  filter_set_a: assert property (resp_valid && sf_support && resp_kind == crl_pkg::rd_no_snoop |=>
    done_illegal || done_state != crl_pkg::shared_clean) else $error("filter set broken");
  cmo_ack_a: assert property (cmo_valid |=> cmo_done) else $error("maintenance not acknowledged");
  five_state_a: assert property (done |-> done_state inside {crl_pkg::invalid, crl_pkg::unique_clean,
    crl_pkg::unique_dirty, crl_pkg::shared_clean, crl_pkg::shared_dirty}) else $error("state code out of range");
endmodule
bind crl_line_state crl_line_state_asserts u_crl_line_state_asserts (.sys_clk, .rst, .sf_support, .resp_valid,
  .resp_kind, .resp_bits, .cmo_valid, .done, .done_state, .done_illegal, .cmo_done);

// file: crl_ic_model.sv
`timescale 1ns/1ps
module crl_ic_model (
  input  wire logic             sys_clk,
  input  wire logic             go,
  input  wire logic [1:0]       idx,
  input  wire crl_pkg::crl_read_type kind,
  input  wire logic             shared_in,
  input  wire logic             bad,
  input  wire logic [3:0]       lat,
  output logic                  resp_valid,
  output logic [1:0]            resp_idx,
  output crl_pkg::crl_read_type resp_kind,
  output logic [1:0]            resp_bits
);
  logic [3:0] cnt_reg = 4'h0;
  initial resp_valid = 1'b0;
  initial resp_bits = 2'h3;
  // Between answers the bits toggle so a stale value is never mistaken for a response.
  always @(negedge sys_clk) begin
    if (go) begin
      cnt_reg <= lat;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
    if (cnt_reg == 4'h1) begin
      resp_valid <= 1'b1;
      resp_idx <= idx;
      resp_kind <= kind;
      resp_bits <= {shared_in && kind != crl_pkg::rd_no_snoop, bad};
    end else begin
      resp_valid <= 1'b0;
      resp_bits <= ~resp_bits;
    end
  end
endmodule

// file: crl_line_state_tb_top.sv
`timescale 1ns/1ps
module crl_line_state_tb_top;
  logic sys_clk = 1'b0, rst = 1'b1, sf_support = 1'b1, opt_no_alloc = 1'b0, opt_share = 1'b0, opt_drop = 1'b0;
  logic req_valid = 1'b0, snoop_valid = 1'b0, cmo_valid = 1'b0, load_valid = 1'b0, shared_in = 1'b0, bad = 1'b0;
  logic resp_valid, done, done_illegal, done_snooped, cmo_done;
  logic [1:0] req_idx = 2'h0, snoop_idx = 2'h0, cmo_idx = 2'h0, load_idx = 2'h0, look_idx = 2'h0, resp_idx, resp_bits;
  logic [3:0] lat = 4'h1;
  crl_pkg::crl_state_type snoop_state = crl_pkg::invalid, load_state = crl_pkg::invalid, look_state, done_state;
  crl_pkg::crl_read_type kind = crl_pkg::rd_clean, resp_kind;
  int errors = 0, checked = 0;
  initial forever #2.5 sys_clk = ~sys_clk;
  crl_line_state u_crl_line_state (.sys_clk, .rst, .sf_support, .opt_no_alloc, .opt_share, .opt_drop, .req_valid,
    .req_idx, .resp_valid, .resp_idx, .resp_kind, .resp_bits, .snoop_valid, .snoop_idx, .snoop_state, .cmo_valid,
    .cmo_idx, .load_valid, .load_idx, .load_state, .look_idx, .look_state, .done, .done_state, .done_illegal,
    .done_snooped, .cmo_done);
  crl_ic_model u_crl_ic_model (.sys_clk, .go(req_valid), .idx(req_idx), .kind, .shared_in, .bad, .lat,
    .resp_valid, .resp_idx, .resp_kind, .resp_bits);
  // ****************************************************************
  // Compare and drive tasks
  // ****************************************************************
  task automatic chk_st(string what, crl_pkg::crl_state_type exp, crl_pkg::crl_state_type got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %s seen %s", what, exp.name(), got.name());
    end
  endtask
  task automatic chk_bit(string what, logic exp, logic got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Loads the start state, issues the read and optionally snoops the line while it is outstanding.
  task automatic rd(logic [1:0] i, crl_pkg::crl_state_type st, crl_pkg::crl_read_type k, logic sh, logic bd,
                    logic sp, crl_pkg::crl_state_type ex, logic il);
    int n;
    @(negedge sys_clk);
    load_valid <= 1'b1;
    load_idx <= i;
    load_state <= st;
    @(negedge sys_clk);
    load_valid <= 1'b0;
    kind <= k;
    shared_in <= sh;
    bad <= bd;
    req_idx <= i;
    req_valid <= 1'b1;
    lat <= sp ? 4'h4 : 4'h1;
    @(negedge sys_clk);
    req_valid <= 1'b0;
    snoop_valid <= sp;
    snoop_idx <= i;
    snoop_state <= crl_pkg::shared_dirty;
    @(negedge sys_clk);
    snoop_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("done", 1'b1, done);
    chk_st("end state", ex, done_state);
    chk_bit("illegal", il, done_illegal);
    chk_bit("snooped", sp, done_snooped);
    look_idx <= i;
    @(negedge sys_clk);
    chk_st("line", ex, look_state);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_clean();
    rd(2'h0, crl_pkg::invalid, crl_pkg::rd_clean, 1, 0, 0, crl_pkg::shared_clean, 0);
    rd(2'h0, crl_pkg::invalid, crl_pkg::rd_clean, 0, 0, 0, crl_pkg::unique_clean, 0);
    rd(2'h1, crl_pkg::shared_dirty, crl_pkg::rd_clean, 1, 0, 0, crl_pkg::shared_dirty, 0);
    rd(2'h1, crl_pkg::unique_dirty, crl_pkg::rd_clean, 0, 0, 0, crl_pkg::unique_dirty, 0);
  endtask
  task automatic s_snap();
    rd(2'h2, crl_pkg::invalid, crl_pkg::rd_snapshot, 1, 0, 0, crl_pkg::invalid, 0);
    rd(2'h2, crl_pkg::shared_clean, crl_pkg::rd_snapshot, 0, 0, 0, crl_pkg::unique_clean, 0);
    rd(2'h3, crl_pkg::shared_dirty, crl_pkg::rd_snapshot, 1, 0, 0, crl_pkg::shared_dirty, 0);
  endtask
  task automatic s_nosn();
    rd(2'h0, crl_pkg::invalid, crl_pkg::rd_no_snoop, 0, 0, 0, crl_pkg::unique_clean, 0);
    rd(2'h3, crl_pkg::shared_dirty, crl_pkg::rd_no_snoop, 0, 0, 0, crl_pkg::unique_dirty, 0);
  endtask
  task automatic s_bad();
    rd(2'h0, crl_pkg::invalid, crl_pkg::rd_clean, 0, 1, 0, crl_pkg::invalid, 1);
    rd(2'h1, crl_pkg::unique_clean, crl_pkg::rd_snapshot, 1, 0, 0, crl_pkg::unique_clean, 1);
  endtask
  task automatic s_snoop();
    rd(2'h1, crl_pkg::shared_clean, crl_pkg::rd_clean, 1, 0, 1, crl_pkg::shared_dirty, 0);
  endtask
  task automatic s_opts();
    sf_support <= 1'b0;
    opt_drop <= 1'b1;
    rd(2'h0, crl_pkg::invalid, crl_pkg::rd_clean, 1, 0, 0, crl_pkg::invalid, 0);
    sf_support <= 1'b1;
    opt_drop <= 1'b0;
    opt_share <= 1'b1;
    rd(2'h0, crl_pkg::invalid, crl_pkg::rd_clean, 0, 0, 0, crl_pkg::shared_clean, 0);
    opt_share <= 1'b0;
    opt_no_alloc <= 1'b1;
    rd(2'h2, crl_pkg::unique_clean, crl_pkg::rd_no_snoop, 0, 0, 0, crl_pkg::invalid, 0);
    opt_no_alloc <= 1'b0;
  endtask
  task automatic s_cmo();
    rd(2'h2, crl_pkg::invalid, crl_pkg::rd_clean, 0, 0, 0, crl_pkg::unique_clean, 0);
    cmo_valid <= 1'b1;
    cmo_idx <= 2'h2;
    @(negedge sys_clk);
    cmo_valid <= 1'b0;
    chk_bit("cmo done", 1'b1, cmo_done);
    chk_st("line after cmo", crl_pkg::unique_clean, look_state);
  endtask
  task automatic finish_test();
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk_st("reset line", crl_pkg::invalid, look_state);
    s_clean();
    s_snap();
    s_nosn();
    s_bad();
    s_snoop();
    s_opts();
    s_cmo();
    finish_test();
  end
  initial begin
    #20000;
    errors++;
    finish_test();
  end
endmodule
